// >>> core/ird_dma.sv
// Functional notes
// - Next pointer 16-byte aligned, continue ignores it unless concatenating
// - Concatenating code 1 continues, 0 ends
// - Final-buffer code sizes next block, 0 ends
// - Transfer result copies control low half
// - Residual count written per packet or completion
// - Codes 1-8 count block, 9-15 reserved
// - Appended descriptors picked up after wake
// - Concatenating fills every buffer completely
// - Spanning packet keeps first and new state
// - Interim buffers get no status, no state
// - Success: final status, then first status
// - Concatenating error backs packet out, no status
// - Command 2 continue, 3 final buffer
// - Control bit selects placement mode
`timescale 1ns/1ns
`include "ird_map.svh"
module ird_dma (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Host memory master
  output ird_pkg::ird_mem_t mem_o,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  // Received packet stream
  input wire ird_pkg::ird_pkt_t pkt_i,
  output logic pkt_ready
);
  import ird_pkg::*;

  // Software registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] cmdptr_q, cmdptr_d;
  logic [31:0] rdata_q, rdata_d;
  // Sequencer state
  ird_state_t st_q, st_d;
  logic [27:0] ptr_q, ptr_d;
  logic [2:0][31:0] word_q, word_d;
  logic [1:0] fw_q, fw_d;
  logic [15:0] off_q, off_d;
  logic [31:0] wdat_q, wdat_d;
  logic inpkt_q, inpkt_d;
  logic last_q, last_d;
  logic err_q, err_d;
  logic refetch_q, refetch_d;
  logic skip_q, skip_d;
  logic wake_q, wake_d; // Wake seen before the context parked
  // State saved at packet start
  logic [27:0] sv_ptr_q, sv_ptr_d;
  logic [2:0][31:0] sv_word_q, sv_word_d;
  logic [15:0] sv_off_q, sv_off_d;
  // Decoder outputs
  ird_desc_t desc;
  logic [27:0] adv_ptr;
  logic adv_go;
  logic adv_end;
  // Derived terms
  logic concat, run, wake, halt, full, span;
  logic [15:0] room;
  logic [15:0] xfer;

  // Descriptor decode and advance choice
  ird_desc_dec u_dec (
    .words(word_q),
    .concat(concat),
    .cur_ptr(ptr_q),
    .desc(desc),
    .adv_ptr(adv_ptr),
    .adv_go(adv_go),
    .adv_end(adv_end)
  );

  assign concat = ctrl_q[`IRD_CTRL_CONCAT];
  assign run = ctrl_q[`IRD_CTRL_RUN];
  assign wake = reg_wr && (reg_addr == `IRD_OFF_WAKE);
  assign room = desc.buffer_size_count - off_q;
  assign full = room < `IRD_QUAD_BYTES;
  assign span = sv_ptr_q != ptr_q;
  assign xfer = {ctrl_q[15:11], st_q != S_IDLE, ctrl_q[9:0]};
  assign reg_rdata = rdata_q;
  assign pkt_ready = ((st_q == S_RUN) && !full && run) || (st_q == S_DRAIN);

  // Memory request from current state
  always_comb
  begin
    mem_o = '0;
    case (st_q)
      S_FETCH:
      begin
        mem_o.req = 1'b1;
        mem_o.addr = {ptr_q, 2'(fw_q), 2'h0};
      end
      S_WDATA:
      begin
        mem_o.req = 1'b1;
        mem_o.we = 1'b1;
        mem_o.addr = desc.buffer_base_ptr + {16'h0, off_q};
        mem_o.wdata = wdat_q;
      end
      S_STFIN:
      begin
        mem_o.req = 1'b1;
        mem_o.we = 1'b1;
        mem_o.addr = {ptr_q, `IRD_STAT_OFF};
        mem_o.wdata = {xfer, room};
      end
      S_STFIRST:
      begin
        // First buffer was filled to its end
        mem_o.req = 1'b1;
        mem_o.we = 1'b1;
        mem_o.addr = {sv_ptr_q, `IRD_STAT_OFF};
        mem_o.wdata = {xfer, 16'h0};
      end
      default:
      begin
        mem_o = '0;
      end
    endcase
  end

  // Register writes and read data
  always_comb
  begin
    ctrl_d = ctrl_q;
    cmdptr_d = cmdptr_q;
    rdata_d = 32'h0;
    if (reg_wr && (reg_addr == `IRD_OFF_CTRL))
    begin
      ctrl_d = reg_wdata;
    end
    else if (reg_wr && (reg_addr == `IRD_OFF_CMDPTR))
    begin
      cmdptr_d = reg_wdata;
    end
    // Hardware stop wins over a write
    if (halt)
    begin
      ctrl_d[`IRD_CTRL_RUN] = 1'b0;
    end
    ctrl_d[`IRD_CTRL_ACTIVE] = 1'b0;
    if (reg_rd && (reg_addr == `IRD_OFF_CTRL))
    begin
      rdata_d = {ctrl_q[31:16], xfer};
    end
    else if (reg_rd && (reg_addr == `IRD_OFF_CMDPTR))
    begin
      rdata_d = cmdptr_q;
    end
    else if (reg_rd && (reg_addr == `IRD_OFF_STATUS))
    begin
      rdata_d = {ptr_q, 4'(st_q)};
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `IRD_CTRL_RST;
      cmdptr_q <= `IRD_CMDPTR_RST;
      rdata_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cmdptr_q <= cmdptr_d;
      rdata_q <= rdata_d;
    end
  end

  // Context sequencer next state
  always_comb
  begin
    st_d = st_q;
    ptr_d = ptr_q;
    word_d = word_q;
    fw_d = fw_q;
    off_d = off_q;
    wdat_d = wdat_q;
    inpkt_d = inpkt_q;
    last_d = last_q;
    err_d = err_q;
    refetch_d = refetch_q;
    skip_d = skip_q;
    sv_ptr_d = sv_ptr_q;
    sv_word_d = sv_word_q;
    sv_off_d = sv_off_q;
    wake_d = wake_q || wake;
    halt = 1'b0;
    case (st_q)
      S_IDLE:
      begin
        // Start at the program pointer
        if (run)
        begin
          ptr_d = cmdptr_q[31:4];
          fw_d = 2'h0;
          refetch_d = 1'b0;
          skip_d = 1'b0;
          inpkt_d = 1'b0;
          st_d = S_FETCH;
        end
      end
      S_FETCH:
      begin
        if (mem_gnt)
        begin
          st_d = S_FWAIT;
        end
      end
      S_FWAIT:
      begin
        if (mem_rvalid)
        begin
          word_d[fw_q] = mem_rdata;
          fw_d = fw_q + 2'h1;
          st_d = S_FETCH;
          if (fw_q == 2'h2)
          begin
            fw_d = 2'h0;
            st_d = (refetch_q || skip_q) ? S_ADV : S_RUN;
            if (!refetch_q)
            begin
              off_d = 16'h0;
            end
          end
        end
      end
      S_ADV:
      begin
        refetch_d = 1'b0;
        if (skip_q && (desc.cmd == `IRD_CMD_FINAL))
        begin
          skip_d = 1'b0;
        end
        if (adv_go)
        begin
          ptr_d = adv_ptr;
          st_d = S_FETCH;
        end
        else if (adv_end)
        begin
          st_d = S_APPEND;
        end
        else
        begin
          halt = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_APPEND:
      begin
        if (!run)
        begin
          st_d = S_IDLE;
        end
        else if (wake || wake_q)
        begin
          // A wake arriving now stays pending
          refetch_d = 1'b1;
          wake_d = wake;
          st_d = S_FETCH;
        end
      end
      S_RUN:
      begin
        if (!run && !inpkt_q)
        begin
          st_d = S_IDLE;
        end
        else if (pkt_i.valid && full && run)
        begin
          if (!concat && inpkt_q && (desc.cmd == `IRD_CMD_FINAL))
          begin
            st_d = S_DRAIN;
          end
          else
          begin
            st_d = S_ADV;
          end
        end
        else if (pkt_i.valid && run)
        begin
          wdat_d = pkt_i.data;
          last_d = pkt_i.last;
          err_d = pkt_i.err;
          st_d = S_WDATA;
          if (!inpkt_q)
          begin
            inpkt_d = 1'b1;
            sv_ptr_d = ptr_q;
            sv_word_d = word_q;
            sv_off_d = off_q;
          end
        end
      end
      S_WDATA:
      begin
        if (mem_gnt)
        begin
          off_d = off_q + `IRD_QUAD_BYTES;
          st_d = last_q ? S_END : S_RUN;
        end
      end
      S_DRAIN:
      begin
        // Overflow bytes are dropped
        if (pkt_i.valid && pkt_i.last)
        begin
          err_d = pkt_i.err;
          st_d = S_END;
        end
      end
      S_END:
      begin
        inpkt_d = 1'b0;
        if (err_q && concat)
        begin
          ptr_d = sv_ptr_q;
          word_d = sv_word_q;
          off_d = sv_off_q;
          st_d = S_RUN;
        end
        else if (concat || desc.upd)
        begin
          st_d = S_STFIN;
        end
        else
        begin
          skip_d = desc.cmd != `IRD_CMD_FINAL;
          st_d = S_ADV;
        end
      end
      S_STFIN:
      begin
        if (mem_gnt)
        begin
          if (concat && span)
          begin
            st_d = S_STFIRST;
          end
          else if (concat)
          begin
            st_d = S_RUN;
          end
          else
          begin
            skip_d = desc.cmd != `IRD_CMD_FINAL;
            st_d = S_ADV;
          end
        end
      end
      S_STFIRST:
      begin
        if (mem_gnt)
        begin
          sv_ptr_d = ptr_q;
          st_d = S_RUN;
        end
      end
      default:
      begin
        st_d = S_IDLE;
      end
    endcase
  end

  // Context sequencer storage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= S_IDLE;
      ptr_q <= 28'h0;
      word_q <= '0;
      fw_q <= 2'h0;
      off_q <= 16'h0;
      wdat_q <= 32'h0;
      inpkt_q <= 1'b0;
      last_q <= 1'b0;
      err_q <= 1'b0;
      refetch_q <= 1'b0;
      skip_q <= 1'b0;
      sv_ptr_q <= 28'h0;
      sv_word_q <= '0;
      sv_off_q <= 16'h0;
      wake_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ptr_q <= ptr_d;
      word_q <= word_d;
      fw_q <= fw_d;
      off_q <= off_d;
      wdat_q <= wdat_d;
      inpkt_q <= inpkt_d;
      last_q <= last_d;
      err_q <= err_d;
      refetch_q <= refetch_d;
      skip_q <= skip_d;
      sv_ptr_q <= sv_ptr_d;
      sv_word_q <= sv_word_d;
      sv_off_q <= sv_off_d;
      wake_q <= wake_d;
    end
  end

  // Good packet end leads to final status in fill mode
  chk_stat_after_data: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_WDATA && mem_gnt && last_q && !err_q && concat) |-> ##2 (st_q == S_STFIN))
    else $error("final status not written after last data");

  // Backout restores saved position
  chk_backout_restore: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_END && err_q && concat) |=>
      (st_q == S_RUN && ptr_q == $past(sv_ptr_q) && off_q == $past(sv_off_q)))
    else $error("backout did not restore saved state");

  // No status writes after an error
  chk_no_err_stat: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_END && err_q && concat) |=> !(mem_o.req && mem_o.we && st_q != S_WDATA) [*3])
    else $error("status written for a failed packet");

  // First descriptor written right after final
  chk_first_after: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_STFIN && mem_gnt && concat && span) |=>
      (st_q == S_STFIRST && mem_o.addr == {$past(sv_ptr_q), `IRD_STAT_OFF}))
    else $error("first descriptor status not next");

  // Continue command steps to next contiguous slot
  chk_cont_next: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_ADV && !concat && desc.cmd == `IRD_CMD_CONT) |=>
      (st_q == S_FETCH && ptr_q == $past(ptr_q) + 28'h1))
    else $error("continue command did not step by one slot");

  // End code parks the context
  chk_end_parks: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_ADV && concat && desc.z == `IRD_Z_END) |=> (st_q == S_APPEND))
    else $error("end of program not parked");

  // Wake re-reads the same descriptor
  chk_append_wake: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_APPEND && run && (wake || wake_q)) |=>
      (st_q == S_FETCH && ptr_q == $past(ptr_q)))
    else $error("wake did not refetch last descriptor");

  // Full buffer moves on in fill mode
  chk_fill_advance: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_RUN && pkt_i.valid && full && run && concat) |=> (st_q == S_ADV))
    else $error("full buffer did not advance");

  // Interim buffers leave saved state alone
  chk_interim_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    (inpkt_q && $past(inpkt_q) && st_q != S_STFIRST) |-> $stable(sv_ptr_q))
    else $error("saved state changed inside a packet");

  // Reserved block code stops the context
  chk_z_reserved: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == S_ADV && !concat && desc.cmd == `IRD_CMD_FINAL && desc.z > `IRD_Z_MAX)
      |=> (st_q == S_IDLE && !run))
    else $error("reserved block code not refused");
endmodule : ird_dma

// >>> core/ird_map.svh
`ifndef IRD_MAP_SVH
`define IRD_MAP_SVH
// Register byte offsets
`define IRD_OFF_CTRL 4'h0
`define IRD_OFF_CMDPTR 4'h4
`define IRD_OFF_WAKE 4'h8
`define IRD_OFF_STATUS 4'hc
// Control register bit positions
`define IRD_CTRL_CONCAT 31
`define IRD_CTRL_RUN 15
`define IRD_CTRL_ACTIVE 10
// Reset values
`define IRD_CTRL_RST 32'h0
`define IRD_CMDPTR_RST 32'h0
// Descriptor word 0 field positions
`define IRD_W0_CMD 28
`define IRD_W0_UPD 27
`define IRD_W0_BR 18
// Descriptor encodings
`define IRD_CMD_CONT 4'h2
`define IRD_CMD_FINAL 4'h3
`define IRD_BR_ALWAYS 2'h3
`define IRD_Z_END 4'h0
`define IRD_Z_ONE 4'h1
`define IRD_Z_MAX 4'h8
// Status quadlet offset inside a descriptor
`define IRD_STAT_OFF 4'hc
// Bytes per data quadlet
`define IRD_QUAD_BYTES 16'h4
`endif

// >>> core/ird_pkg.sv
package ird_pkg;
  // Decoded receive descriptor
  typedef struct packed {
    logic [3:0] cmd;
    logic upd;
    logic [1:0] br;
    logic [15:0] buffer_size_count;
    logic [31:0] buffer_base_ptr;
    logic [27:0] next_descriptor_ptr;
    logic [3:0] z;
  } ird_desc_t;
  // Host memory master request
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ird_mem_t;
  // Received packet quadlet
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic last;
    logic err;
  } ird_pkt_t;
  // Context sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_FWAIT, S_ADV, S_APPEND, S_RUN,
    S_WDATA, S_DRAIN, S_END, S_STFIN, S_STFIRST
  } ird_state_t;
endpackage : ird_pkg

// >>> core/ird_desc_dec.sv
`timescale 1ns/1ns
`include "ird_map.svh"
module ird_desc_dec (
  // Raw descriptor words 0 to 2
  input wire logic [2:0][31:0] words,
  // Placement mode and current position
  input wire logic concat,
  input wire logic [27:0] cur_ptr,
  // Decoded descriptor
  output ird_pkg::ird_desc_t desc,
  // Where to go once this buffer is done
  output logic [27:0] adv_ptr,
  output logic adv_go,
  output logic adv_end
);
  import ird_pkg::*;

  // Block size code names a legal block
  function automatic logic z_blk(input logic [3:0] z);
    z_blk = (z != `IRD_Z_END) && (z <= `IRD_Z_MAX);
  endfunction : z_blk

  // Field extraction
  always_comb
  begin
    desc.cmd = words[0][`IRD_W0_CMD +: 4];
    desc.upd = words[0][`IRD_W0_UPD];
    desc.br = words[0][`IRD_W0_BR +: 2];
    desc.buffer_size_count = words[0][15:0];
    desc.buffer_base_ptr = words[1];
    desc.next_descriptor_ptr = words[2][31:4];
    desc.z = words[2][3:0];
  end

  // Next descriptor choice
  always_comb
  begin
    adv_ptr = desc.next_descriptor_ptr;
    adv_go = 1'b0;
    adv_end = 1'b0;
    if (concat)
    begin
      adv_go = (desc.z == `IRD_Z_ONE) && z_blk(desc.z);
      adv_end = (desc.z == `IRD_Z_END);
    end
    else if (desc.cmd == `IRD_CMD_CONT)
    begin
      adv_ptr = cur_ptr + 28'h1;
      adv_go = 1'b1;
    end
    else
    begin
      adv_go = z_blk(desc.z);
      adv_end = (desc.z == `IRD_Z_END);
    end
  end
endmodule : ird_desc_dec

// >>> test/ird_host_mem.sv
`timescale 1ns/1ns
module ird_host_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests from the block and grant wait states
  input wire ird_pkg::ird_mem_t mem_o,
  input wire logic [1:0] slow,
  // Answers to the block
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  import ird_pkg::*;
  logic [31:0] mem [0:255]; // Host words, byte address bits 9:2
  logic [31:0] stat_log [$]; // Descriptor status write addresses, in order
  logic [1:0] wait_cnt; // Cycles the open request has waited
  logic [31:0] last_rd; // Last word handed back
  // Grant after the wait states, read data one cycle after the grant
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      wait_cnt <= 2'h0;
      last_rd <= 32'h0;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_gnt <= mem_o.req && !mem_gnt && (wait_cnt >= slow);
      wait_cnt <= (mem_o.req && !mem_gnt) ? wait_cnt + 2'h1 : 2'h0;
      // Request taken on this edge
      if (mem_o.req && mem_gnt)
      begin
        if (mem_o.we)
        begin
          mem[mem_o.addr[9:2]] <= mem_o.wdata;
          // Only the descriptor area is logged
          if (mem_o.addr[9:8] == 2'h1 && mem_o.addr[3:0] == 4'hc)
            stat_log.push_back(mem_o.addr);
        end
        else
        begin
          mem_rvalid <= 1'b1;
          last_rd <= mem[mem_o.addr[9:2]];
        end
      end
    end
  end
  // Read bus is not held once the answer cycle is over
  assign mem_rdata = mem_rvalid ? last_rd : ~last_rd;
endmodule : ird_host_mem

// >>> test/test_ird_dma.sv
`timescale 1ns/1ns
module test_ird_dma;
  import ird_pkg::*;
  logic clk = 1'b0; // Bench clock
  logic reset_n = 1'b0; // Bench reset
  logic [3:0] reg_addr = 4'h0; // Register port
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  ird_mem_t mem_o; // Memory port
  logic mem_gnt;
  logic mem_rvalid;
  logic [31:0] mem_rdata;
  logic [1:0] slow = 2'h0;
  ird_pkt_t pkt_i = '0; // Packet stream
  logic pkt_ready;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  ird_dma dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_o(mem_o),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .pkt_i(pkt_i),
    .pkt_ready(pkt_ready));
  ird_host_mem host_u (.clk(clk), .reset_n(reset_n), .mem_o(mem_o), .slow(slow),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // 250 MHz clock
  always #2 clk = ~clk;
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One-cycle register write
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // One-cycle register read, data taken in the following cycle
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read
  // Build one continue descriptor in host memory
  task automatic put_desc(input int a, input int buf_a, input int size, input int nxt,
    input logic [3:0] z);
    // always branch, block code as given in z
    host_u.mem[a / 4] = {4'h2, 1'b1, 7'h0, 2'h3, 2'h0, size[15:0]};
    host_u.mem[a / 4 + 1] = buf_a;
    host_u.mem[a / 4 + 2] = {nxt[31:4], z};
    host_u.mem[a / 4 + 3] = 32'h0;
  endtask : put_desc
  // Send one packet of n quadlets
  task automatic send_pkt(input int n, input logic [31:0] d0, input logic err);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      pkt_i <= '{valid: 1'b1, data: d0 + i, last: (i == n - 1), err: err};
      @(negedge clk);
      while (!pkt_ready)
        @(negedge clk);
      @(posedge clk);
      pkt_i <= '0;
    end
  endtask : send_pkt
  // Wait until n status writes have been seen
  task automatic wait_log(input int n);
    for (int i = 0; i < 400 && host_u.stat_log.size() < n; i++)
      @(posedge clk);
    // Let the model's memory update settle first
    @(negedge clk);
    check("status write count", host_u.stat_log.size(), n);
  endtask : wait_log
  // Reset values and plain register access
  task automatic t_regs();
    reg_read(4'h0, rd);
    check("control reset", rd, 32'h0);
    reg_read(4'h8, rd);
    check("wake reads zero", rd, 32'h0);
    reg_write(4'h4, 32'h101);
    reg_read(4'h4, rd);
    check("block start", rd & 32'hfffffff0, 32'h100);
  endtask : t_regs
  // Concatenated stream, spanning packet, backout, append
  task automatic t_stream();
    put_desc(32'h100, 32'h200, 8, 32'h110, 4'h1);
    put_desc(32'h110, 32'h280, 4, 32'h120, 4'h1);
    put_desc(32'h120, 32'h300, 16, 0, 4'h0);
    reg_write(4'h0, 32'h80008000);
    send_pkt(1, 32'ha0000000, 1'b0);
    wait_log(1);
    check("first status addr", host_u.stat_log[0], 32'h10c);
    // run bit must be set before the count is trusted
    check("run in result", host_u.mem[32'h10c / 4] & 32'h80000000, 32'h80000000);
    check("first resid", host_u.mem[32'h10c / 4] & 32'hffff, 32'h4);
    check("first data", host_u.mem[32'h200 / 4], 32'ha0000000);
    slow <= 2'h2;
    send_pkt(4, 32'hb0000000, 1'b0);
    wait_log(3);
    check("final status first", host_u.stat_log[1], 32'h12c);
    check("first status next", host_u.stat_log[2], 32'h10c);
    check("fill a", host_u.mem[32'h204 / 4], 32'hb0000000);
    check("interim data", host_u.mem[32'h280 / 4], 32'hb0000001);
    check("interim no status", host_u.mem[32'h11c / 4], 32'h0);
    check("final data", host_u.mem[32'h304 / 4], 32'hb0000003);
    check("final resid", host_u.mem[32'h12c / 4] & 32'hffff, 32'h8);
    check("first resid zero", host_u.mem[32'h10c / 4] & 32'hffff, 32'h0);
    slow <= 2'h0;
    send_pkt(1, 32'hc0000000, 1'b1);
    repeat (30) @(posedge clk);
    check("no status on error", host_u.stat_log.size(), 3);
    send_pkt(2, 32'hd0000000, 1'b0);
    wait_log(4);
    check("restored offset", host_u.mem[32'h308 / 4], 32'hd0000000);
    check("end fill", host_u.mem[32'h30c / 4], 32'hd0000001);
    check("end resid", host_u.mem[32'h12c / 4] & 32'hffff, 32'h0);
    put_desc(32'h130, 32'h340, 4, 0, 4'h0);
    // only the last descriptor is edited while running
    host_u.mem[32'h128 / 4] = {28'h0000013, 4'h1};
    reg_write(4'h8, 32'h1);
    send_pkt(1, 32'he0000000, 1'b0);
    wait_log(5);
    check("appended status", host_u.stat_log[4], 32'h13c);
    check("appended data", host_u.mem[32'h340 / 4], 32'he0000000);
  endtask : t_stream
  // Per-packet blocks: continue walk, final status, overflow, reserved code
  task automatic t_block();
    reg_write(4'h0, 32'h0);
    put_desc(32'h140, 32'h380, 4, 32'h150, 4'h1);
    put_desc(32'h150, 32'h3a0, 8, 32'h160, 4'h1);
    put_desc(32'h160, 32'h3c0, 4, 32'h170, 4'h9);
    // Continue without status, finals with status
    host_u.mem[32'h140 / 4] = {4'h2, 1'b0, 7'h0, 2'h0, 2'h0, 16'h4};
    host_u.mem[32'h150 / 4] = {4'h3, 1'b1, 7'h0, 2'h3, 2'h0, 16'h8};
    host_u.mem[32'h160 / 4] = {4'h3, 1'b1, 7'h0, 2'h3, 2'h0, 16'h4};
    host_u.mem[32'h3c4 / 4] = 32'h0;
    reg_write(4'h4, 32'h141);
    reg_write(4'h0, 32'h8000);
    send_pkt(2, 32'hf0000000, 1'b0);
    send_pkt(2, 32'h90000000, 1'b0);
    wait_log(7);
    check("walk first data", host_u.mem[32'h380 / 4], 32'hf0000000);
    check("walk next data", host_u.mem[32'h3a0 / 4], 32'hf0000001);
    check("continue no status", host_u.mem[32'h14c / 4], 32'h0);
    check("final status addr", host_u.stat_log[5], 32'h15c);
    check("final status word", host_u.mem[32'h15c / 4], 32'h84000004);
    check("overflow status addr", host_u.stat_log[6], 32'h16c);
    check("overflow status word", host_u.mem[32'h16c / 4], 32'h84000000);
    check("overflow data", host_u.mem[32'h3c0 / 4], 32'h90000000);
    check("overflow dropped", host_u.mem[32'h3c4 / 4], 32'h0);
    reg_read(4'h0, rd);
    check("reserved code stops", rd, 32'h0);
    reg_read(4'hc, rd);
    check("halted position", rd, 32'h160);
  endtask : t_block
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_stream();
    t_block();
    summarize();
  end
endmodule : test_ird_dma
